// *** src/dntb_top.sv ***
// data-acquisition backbone: network setup, bus control, trigger, builder
// Summary of operation
// - after reset, release the phy and load mac and ip from eeprom
// - forced default mode ignores eeprom, uses 192.168.10.16 and default mac
// - link runs at 1 gbps only; no fallback to slower rate
// - tcp stream carries one byte per clock; tcp receive left unused
// - udp register access gives a 32 bit address and 8 bit data
// - each udp register access taken while the local bus is idle is answered by an acknowledge; one arriving while busy is dropped
// - new ip goes to eeprom only; active ip changes at next start
// - local bus gets full address and data byte unchanged
// - local bus controller driven by udp port serves all local modules
// - builder collects measurement data, prepends header, sends to tcp
// - receiver block puts trigger tag on builder path per trigger
// - as backplane master, drive receiver trigger and tag onto backplane
// - as backplane slave, pass backplane trigger to trigger manager
// - trigger manager picks source: mezzanine, nim or backplane
// - builder uses accept, clear and tag for header and send decision
// - receiver captures 12 bit event and 8 bit spill numbers
`timescale 1ns/1ps
module dntb_top
    import dntb_pkg::*;
#(
    parameter int PHY_CYC = PHY_RST_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // network engine setup
    output logic net_phy_rst_n,
    output logic net_eeprom_rd,
    input wire logic [31:0] net_eeprom_ip,
    input wire logic [47:0] net_eeprom_mac,
    input wire logic net_eeprom_valid,
    input wire logic net_force_default,
    output logic [31:0] net_active_ip,
    output logic [47:0] net_active_mac,
    output logic net_ready,
    output logic net_speed_1g,
    output logic net_autofallback_en,
    output logic net_eeprom_wr,
    output logic [31:0] net_eeprom_wr_ip,
    // udp register access
    input wire logic [31:0] udp_addr,
    input wire logic [7:0] udp_wdata,
    input wire logic udp_we,
    input wire logic udp_re,
    output logic [7:0] udp_rdata,
    output logic udp_ack,
    // local bus
    output logic [31:0] lb_addr,
    output logic [7:0] lb_wdata,
    output logic lb_we,
    output logic lb_re,
    input wire logic [7:0] lb_rdata,
    input wire logic lb_ack,
    // tcp stream
    output logic [7:0] tcp_tx_data,
    output logic tcp_tx_valid,
    input wire logic tcp_tx_ready,
    output logic tcp_rx_ready,
    // receiver mezzanine pins
    input wire logic mz_present,
    input wire logic mz_level1,
    input wire logic mz_second_level_accept,
    input wire logic mz_clear,
    input wire logic [11:0] mz_event_num,
    input wire logic [7:0] mz_spill,
    // nim trigger pin
    input wire logic nim_trig,
    // backplane trigger bus
    input wire logic bp_level1_i,
    input wire logic bp_second_level_accept_i,
    input wire logic bp_clear_i,
    input wire logic [11:0] bp_tag_i,
    output logic bp_level1_o,
    output logic bp_second_level_accept_o,
    output logic bp_clear_o,
    output logic [11:0] bp_tag_o,
    output logic bp_oe,
    // measurement builder bus
    input wire logic [7:0] meas_data,
    input wire logic meas_valid,
    input wire logic meas_last,
    output logic meas_ready
);
    initial begin
        if (PHY_CYC < 1)
            $error("phy reset count must be at least one cycle");
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    function automatic logic pick(input dntb_src_t s, input logic a,
                                  input logic b, input logic c);
        case (s)
            SRC_MEZZ: pick = a;
            SRC_NIM: pick = b;
            SRC_BP: pick = c;
            default: pick = 1'b0;
        endcase
    endfunction : pick

    // two-stage synchroniser for every pin input
    localparam int SW = 41;
    logic [SW-1:0] raw, s1_r, s2_r;
    assign raw = {mz_present, mz_level1, mz_second_level_accept, mz_clear, mz_event_num,
                  mz_spill, nim_trig, bp_level1_i, bp_second_level_accept_i, bp_clear_i,
                  bp_tag_i, net_force_default};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
        end
    end
    logic m_pres, m_l1, m_l2, m_clr, n_l1, b_l1, b_l2, b_clr, force_def;
    logic [11:0] m_evt, b_tag;
    logic [7:0] m_spill;
    assign {m_pres, m_l1, m_l2, m_clr, m_evt, m_spill, n_l1, b_l1, b_l2,
            b_clr, b_tag, force_def} = s2_r;

    // control register
    logic [2:0] ctrl_r;
    dntb_src_t src;
    logic bp_master;
    assign src = dntb_src_t'(ctrl_r[CTRL_SRC_LSB +: 2]);
    assign bp_master = ctrl_r[CTRL_BPM_BIT];

    // network setup
    typedef enum logic [1:0] {NI_RST, NI_LOAD, NI_UP} dntb_ni_t;
    dntb_ni_t ni_r;
    logic [$clog2(PHY_CYC+1)-1:0] ni_cnt_r;
    logic force_seen_r;
    assign net_phy_rst_n = (ni_r != NI_RST);
    assign net_eeprom_rd = (ni_r == NI_LOAD) && !force_def;
    assign net_ready = (ni_r == NI_UP);
    assign net_speed_1g = 1'b1;
    assign net_autofallback_en = 1'b0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ni_r <= NI_RST;
            ni_cnt_r <= '0;
            net_active_ip <= '0;
            net_active_mac <= '0;
            force_seen_r <= 1'b0;
        end else begin
            case (ni_r)
                NI_RST: begin
                    ni_cnt_r <= ni_cnt_r + 1'b1;
                    if (ni_cnt_r == ($bits(ni_cnt_r))'(PHY_CYC - 1))
                        ni_r <= NI_LOAD;
                end
                NI_LOAD: begin
                    force_seen_r <= force_def;
                    if (force_def) begin
                        net_active_ip <= DEF_IP;
                        net_active_mac <= DEF_MAC;
                        ni_r <= NI_UP;
                    end else if (net_eeprom_valid) begin
                        net_active_ip <= net_eeprom_ip;
                        net_active_mac <= net_eeprom_mac;
                        ni_r <= NI_UP;
                    end
                end
                NI_UP: ni_r <= NI_UP;
                default: ni_r <= NI_RST;
            endcase
        end
    end

    // local bus controller fed from udp register access
    logic lb_busy_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lb_busy_r <= 1'b0;
            lb_addr <= '0;
            lb_wdata <= '0;
            lb_we <= 1'b0;
            lb_re <= 1'b0;
            udp_rdata <= '0;
            udp_ack <= 1'b0;
        end else begin
            lb_we <= 1'b0;
            lb_re <= 1'b0;
            udp_ack <= 1'b0;
            if (!lb_busy_r && (udp_we || udp_re)) begin
                lb_busy_r <= 1'b1;
                lb_addr <= udp_addr;
                lb_wdata <= udp_wdata;
                lb_we <= udp_we;
                lb_re <= udp_re && !udp_we;
            end else if (lb_busy_r && lb_ack) begin
                lb_busy_r <= 1'b0;
                udp_rdata <= lb_rdata;
                udp_ack <= 1'b1;
            end
        end
    end

    // trigger manager
    logic sel_l1, sel_l2, sel_clr, prev_l1_r, prev_l2_r, prev_clr_r;
    logic l1_p, l2_p, clr_p;
    logic [11:0] nim_cnt_r;
    assign sel_l1 = pick(src, m_l1, n_l1, b_l1);
    assign sel_l2 = pick(src, m_l2, n_l1, b_l2);
    assign sel_clr = pick(src, m_clr, 1'b0, b_clr);
    assign l1_p = sel_l1 && !prev_l1_r;
    assign l2_p = sel_l2 && !prev_l2_r;
    assign clr_p = sel_clr && !prev_clr_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_l1_r <= 1'b0;
            prev_l2_r <= 1'b0;
            prev_clr_r <= 1'b0;
            nim_cnt_r <= '0;
        end else begin
            prev_l1_r <= sel_l1;
            prev_l2_r <= sel_l2;
            prev_clr_r <= sel_clr;
            if (src == SRC_NIM && l1_p)
                nim_cnt_r <= nim_cnt_r + 1'b1;
        end
    end

    // backplane interface
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bp_level1_o <= 1'b0;
            bp_second_level_accept_o <= 1'b0;
            bp_clear_o <= 1'b0;
            bp_tag_o <= '0;
            bp_oe <= 1'b0;
        end else begin
            bp_oe <= bp_master;
            bp_level1_o <= bp_master && m_l1;
            bp_second_level_accept_o <= bp_master && m_l2;
            bp_clear_o <= bp_master && m_clr;
            bp_tag_o <= bp_master ? m_evt : 12'h000;
        end
    end

    // event builder
    typedef enum logic [2:0] {EB_IDLE, EB_WAIT, EB_HDR, EB_DATA,
                              EB_DROP} dntb_eb_t;
    dntb_eb_t eb_r;
    logic [1:0] hdr_idx_r;
    logic [11:0] tag_r;
    logic [7:0] spill_r;
    logic [31:0] evt_cnt_r;
    logic [7:0] push_data;
    logic push_ok;
    dntb_stream_if #(.W(FIFO_W)) fin ();
    dntb_stream_if #(.W(FIFO_W)) fout ();
    always_comb begin
        case (hdr_idx_r)
            2'h0: push_data = HDR_MARK;
            2'h1: push_data = {m_pres, 1'b0, src, tag_r[11:8]};
            2'h2: push_data = tag_r[7:0];
            default: push_data = spill_r;
        endcase
        if (eb_r == EB_DATA)
            push_data = meas_data;
    end
    assign fin.data = push_data;
    assign fin.valid = (eb_r == EB_HDR) || (eb_r == EB_DATA && meas_valid);
    assign push_ok = fin.valid && fin.ready;
    assign meas_ready = (eb_r == EB_DROP) || (eb_r == EB_DATA && fin.ready);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eb_r <= EB_IDLE;
            hdr_idx_r <= '0;
            tag_r <= '0;
            spill_r <= '0;
            evt_cnt_r <= '0;
        end else begin
            case (eb_r)
                EB_IDLE: if (l1_p) begin
                    tag_r <= (src == SRC_MEZZ) ? m_evt :
                             (src == SRC_BP) ? b_tag : nim_cnt_r;
                    spill_r <= (src == SRC_MEZZ) ? m_spill : 8'h00;
                    eb_r <= EB_WAIT;
                end
                EB_WAIT: begin
                    hdr_idx_r <= '0;
                    if (clr_p)
                        eb_r <= EB_DROP;
                    else if (l2_p || src == SRC_NIM)
                        eb_r <= EB_HDR;
                end
                EB_HDR: if (push_ok) begin
                    hdr_idx_r <= hdr_idx_r + 1'b1;
                    if (hdr_idx_r == HDR_LAST)
                        eb_r <= EB_DATA;
                end
                EB_DATA: if (push_ok && meas_last) begin
                    eb_r <= EB_IDLE;
                    evt_cnt_r <= evt_cnt_r + 1'b1;
                end
                EB_DROP: if (meas_valid && meas_last)
                    eb_r <= EB_IDLE;
                default: eb_r <= EB_IDLE;
            endcase
        end
    end

    dntb_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(hclk),
        .rst_n(hresetn),
        .in_s(fin),
        .out_s(fout)
    );
    assign tcp_tx_data = fout.data;
    assign tcp_tx_valid = fout.valid;
    assign fout.ready = tcp_tx_ready;
    assign tcp_rx_ready = 1'b0;

    // ahb-lite register slave, zero wait state
    logic ap_wr_r;
    logic [7:0] ap_off_r;
    logic ap_take;
    assign ap_take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_r <= 1'b0;
            ap_off_r <= '0;
            hrdata <= '0;
        end else begin
            ap_wr_r <= ap_take && hwrite && haddr[31:8] == 24'h000000;
            ap_off_r <= haddr[7:0];
            if (ap_take && !hwrite) begin
                case ({haddr[31:8] == 24'h000000, haddr[7:0]})
                    {1'b1, REG_CTRL}: hrdata <= {29'h0, ctrl_r};
                    {1'b1, REG_STATUS}: hrdata <= {24'h0, lb_busy_r,
                        1'(eb_r), force_seen_r, net_ready, 4'h0} |
                        {24'h0, 1'b0, 3'(eb_r), 4'h0};
                    {1'b1, REG_ACT_IP}: hrdata <= net_active_ip;
                    {1'b1, REG_NEW_IP}: hrdata <= net_eeprom_wr_ip;
                    {1'b1, REG_EVT_CNT}: hrdata <= evt_cnt_r;
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= CTRL_RST;
            net_eeprom_wr <= 1'b0;
            net_eeprom_wr_ip <= '0;
        end else begin
            net_eeprom_wr <= 1'b0;
            if (ap_wr_r && ap_off_r == REG_CTRL)
                ctrl_r <= hwdata[2:0];
            if (ap_wr_r && ap_off_r == REG_NEW_IP) begin
                net_eeprom_wr <= 1'b1;
                net_eeprom_wr_ip <= hwdata;
            end
        end
    end

    // checks
    fixed_speed_a: assert property (
        net_speed_1g && !net_autofallback_en) else $error("speed not fixed");
    phy_release_a: assert property (
        $rose(net_phy_rst_n) |-> $past(ni_r) == NI_RST && $past(ni_cnt_r) ==
        ($bits(ni_cnt_r))'(PHY_CYC - 1)) else $error("phy released early");
    forced_ip_a: assert property (
        ni_r == NI_LOAD && force_def |=> net_active_ip == DEF_IP &&
        net_ready) else $error("default ip not taken");
    ip_hold_a: assert property (
        net_ready && $past(net_ready) |-> $stable(net_active_ip))
        else $error("active ip changed");
    lb_pass_a: assert property (
        !lb_busy_r && udp_we |=> lb_we && lb_addr == $past(udp_addr) &&
        lb_wdata == $past(udp_wdata)) else $error("local bus mismatch");
    ack_after_a: assert property (
        udp_ack |-> $past(lb_ack) && $past(lb_busy_r) && !lb_busy_r)
        else $error("ack before local access");
    drop_nopush_a: assert property (
        eb_r == EB_DROP |-> !fin.valid && meas_ready)
        else $error("cleared event pushed");
    hdr_mark_a: assert property (
        eb_r == EB_WAIT && l2_p && !clr_p ##1 fin.valid |->
        fin.data == HDR_MARK) else $error("header mark missing");
    bp_drive_a: assert property (
        bp_oe |-> $past(bp_master) && bp_tag_o == $past(m_evt))
        else $error("backplane drive wrong");
endmodule : dntb_top

// *** src/dntb_pkg.sv ***
// constants shared by the data-acquisition backbone
package dntb_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ACT_IP = 8'h08;
    localparam logic [7:0] REG_NEW_IP = 8'h0C;
    localparam logic [7:0] REG_EVT_CNT = 8'h10;
    // control fields
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_BPM_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    // network defaults
    localparam logic [31:0] DEF_IP = 32'hC0A80A10;
    localparam logic [47:0] DEF_MAC = 48'h020000000001; // arbitrary value
    // timing
    localparam int CLK_NS = 10;
    localparam int PHY_RST_NS = 1000;
    localparam int PHY_RST_CYC = (PHY_RST_NS + CLK_NS - 1) / CLK_NS;
    // event header
    localparam logic [7:0] HDR_MARK = 8'hA5;
    localparam logic [1:0] HDR_LAST = 2'h3;
    localparam int FIFO_W = 8;
    localparam int FIFO_DEPTH = 8;
    typedef enum logic [1:0] {SRC_MEZZ, SRC_NIM, SRC_BP} dntb_src_t;
endpackage : dntb_pkg

// *** src/dntb_stream_if.sv ***
// valid/ready byte stream between builder, fifo and network engine
`timescale 1ns/1ps
interface dntb_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : dntb_stream_if

// *** src/dntb_fifo.sv ***
// small first-in first-out buffer for the event stream
`timescale 1ns/1ps
module dntb_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // streams
    dntb_stream_if.snk in_s,
    dntb_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1)
            $error("depth must be a power of two of at least 2");
    end
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r, rd_r;
    logic [AW:0] cnt_r;
    logic push, pop;
    assign in_s.ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_s.valid = (cnt_r != '0);
    assign out_s.data = mem[rd_r];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;
    always_ff @(posedge clk) begin
        if (push)
            mem[wr_r] <= in_s.data;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push)
                wr_r <= wr_r + 1'b1;
            if (pop)
                rd_r <= rd_r + 1'b1;
            if (push && !pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop && !push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
    occupancy_a: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_r <= (AW+1)'(DEPTH)) else $error("fifo overfilled");
endmodule : dntb_fifo

// *** dv/dntb_far_model.sv ***
// far-side model: local bus targets and a tcp byte sink
`timescale 1ns/1ps
module dntb_far_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // local bus
    input wire logic [31:0] lb_addr,
    input wire logic [7:0] lb_wdata,
    input wire logic lb_we,
    input wire logic lb_re,
    output logic [7:0] lb_rdata,
    output logic lb_ack,
    // tcp sink
    input wire logic stall,
    output logic tcp_tx_ready
);
    logic [7:0] mem [16];
    logic [1:0] wait_n;
    logic busy, rd;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {busy, rd, lb_ack, tcp_tx_ready} <= 4'h0;
            lb_rdata <= 8'h00;
            wait_n <= 2'h0;
        end else begin
            tcp_tx_ready <= !stall && ($urandom % 4 != 0);
            lb_ack <= 1'b0;
            // read byte inverted every cycle outside a read answer, so the old byte shows every other cycle
            lb_rdata <= ~lb_rdata;
            if (lb_we || lb_re) begin
                {busy, rd} <= {1'b1, lb_re};
                wait_n <= 2'($urandom);
            end else if (busy && wait_n != 2'h0) begin
                wait_n <= wait_n - 2'h1;
            end else if (busy) begin
                busy <= 1'b0;
                lb_ack <= 1'b1;
                if (rd) lb_rdata <= mem[lb_addr[3:0]];
                else mem[lb_addr[3:0]] <= lb_wdata;
            end
        end
    end
endmodule : dntb_far_model

// *** dv/tb_dntb_top.sv ***
// self-checking bench for the data-acquisition backbone
`timescale 1ns/1ps
module tb_dntb_top;
    import dntb_pkg::*;
    localparam int PHY_N = 8;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, stall, bpm;
    logic [31:0] haddr, hwdata, hrdata, net_eeprom_ip, net_active_ip;
    logic [31:0] net_eeprom_wr_ip, udp_addr, lb_addr, nip, cap_ip, ua;
    logic [47:0] net_eeprom_mac, net_active_mac;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic net_phy_rst_n, net_eeprom_rd, net_eeprom_valid, net_force_default;
    logic net_ready, net_speed_1g, net_autofallback_en, net_eeprom_wr;
    logic [7:0] udp_wdata, udp_rdata, lb_wdata, lb_rdata, tcp_tx_data;
    logic [7:0] mz_spill, meas_data, ud;
    logic udp_we, udp_re, udp_ack, lb_we, lb_re, lb_ack, tcp_tx_valid;
    logic tcp_tx_ready, tcp_rx_ready, mz_present, bp_level1_o, bp_oe;
    logic meas_valid, meas_last, meas_ready, rd_seen, b_seen;
    logic [11:0] tag, bp_tag_o, b_tag;
    logic [6:0] trg;
    logic [15:0] exp_q[$];
    logic [15:0] m;
    int n_fail = 0, checks_done = 0, refused = 0, wr_cnt = 0;

    dntb_top #(.PHY_CYC(PHY_N)) dut_u (.*, .hready(hreadyout),
        .mz_level1(trg[0]), .mz_second_level_accept(trg[1]), .mz_clear(trg[2]),
        .mz_event_num(tag), .nim_trig(trg[3]), .bp_level1_i(trg[4]),
        .bp_second_level_accept_i(trg[5]), .bp_clear_i(trg[6]), .bp_tag_i(tag),
        .bp_second_level_accept_o(), .bp_clear_o());
    dntb_far_model far_u (.*);

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // eeprom stand-in
    always @(posedge hclk) net_eeprom_valid <= net_eeprom_rd === 1'b1;
    // watcher: oldest note per streamed byte
    always @(negedge hclk) begin
        if (net_eeprom_rd === 1'b1) rd_seen = 1'b1;
        if (net_eeprom_wr === 1'b1) begin
            wr_cnt++;
            cap_ip = net_eeprom_wr_ip;
        end
        if (bp_level1_o === 1'b1 && !b_seen) begin
            b_seen = 1'b1;
            b_tag = bp_tag_o;
        end
        if (meas_valid && meas_ready !== 1'b1) refused++;
        if (tcp_tx_valid === 1'b1 && tcp_tx_ready === 1'b1) begin
            if (exp_q.size() == 0) chk("tcp extra", 1, 0);
            else begin
                m = exp_q.pop_front();
                chk("tcp byte", tcp_tx_data & m[15:8], m[7:0] & m[15:8]);
            end
        end
    end

    task chk(input string nm, input logic [63:0] seen, input logic [63:0] e);
        checks_done++;
        if (seen !== e) begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", nm, e, seen);
        end
    endtask : chk
    task results;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    task tmo(input int k);
        if (k >= 400) begin
            chk("timeout", 0, 1);
            results();
        end
    endtask : tmo
    task edge_rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 400);
        tmo(k);
    endtask : edge_rdy
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        edge_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        edge_rdy();
        rd = hrdata;
    endtask : ahb
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask : wr
    task rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(nm, r, e);
    endtask : rchk
    task do_reset(input logic f);
        int k;
        @(posedge hclk);
        net_force_default <= f;
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd_seen = 1'b0;
        k = 0;
        while (net_phy_rst_n !== 1'b1 && k < 400) begin
            @(negedge hclk);
            k++;
        end
        tmo(k);
        chk("phy hold", k, PHY_N + 1);
        repeat (4) @(negedge hclk);
        chk("net up", net_ready, 1);
    endtask : do_reset
    task udp(input logic w, input logic [31:0] a, input logic [7:0] d,
             input logic [7:0] e);
        int k;
        logic saw;
        @(posedge hclk);
        udp_addr <= a;
        udp_wdata <= d;
        udp_we <= w;
        udp_re <= !w;
        @(posedge hclk);
        udp_we <= 1'b0;
        udp_re <= 1'b0;
        k = 0;
        saw = 1'b0;
        while (udp_ack !== 1'b1 && k < 400) begin
            @(negedge hclk);
            k++;
            if (lb_we === 1'b1 || lb_re === 1'b1) begin
                chk("lb addr", lb_addr, a);
                chk("lb dir", lb_we, w);
                if (w) chk("lb wdata", lb_wdata, d);
            end
            if (lb_ack === 1'b1) saw = 1'b1;
        end
        tmo(k);
        chk("ack after lb", saw, 1);
        if (!w) chk("udp rdata", udp_rdata, e);
    endtask : udp
    task pulse(input int b);
        @(posedge hclk);
        trg[b] <= 1'b1;
        repeat (4) @(posedge hclk);
        trg[b] <= 1'b0;
        repeat (6) @(posedge hclk);
    endtask : pulse
    task meas(input int n, input logic keep);
        int k;
        logic [7:0] d;
        @(posedge hclk);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            meas_data <= d;
            meas_valid <= 1'b1;
            meas_last <= (i == n - 1);
            if (keep) exp_q.push_back({8'hFF, d});
            k = 0;
            do begin
                @(negedge hclk);
                k++;
            end while (meas_ready !== 1'b1 && k < 400);
            tmo(k);
            @(posedge hclk);
        end
        meas_valid <= 1'b0;
        meas_last <= 1'b0;
    endtask : meas
    task drain;
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 400) begin
            @(posedge hclk);
            k++;
        end
        tmo(k);
    endtask : drain
    // one event from source s; clr drops a mezzanine or backplane event
    task ev(input logic [1:0] s, input int n, input logic clr);
        logic [11:0] t;
        logic [7:0] sp;
        wr(32'(REG_CTRL), {29'h0, bpm, s});
        t = 12'($urandom);
        sp = 8'($urandom);
        @(posedge hclk);
        tag <= t;
        mz_spill <= sp;
        if (!clr) begin
            exp_q.push_back({8'hFF, HDR_MARK});
            exp_q.push_back({s == 1 ? 8'hF0 : 8'hFF,
                             mz_present, 1'b0, s, t[11:8]});
            exp_q.push_back({s == 1 ? 8'h00 : 8'hFF, t[7:0]});
            exp_q.push_back({s == 2 ? 8'h00 : 8'hFF,
                             s == 0 ? sp : 8'h00});
        end
        pulse(s == 0 ? 0 : s == 1 ? 3 : 4);
        if (clr) pulse(s == 0 ? 2 : 6);
        else if (s != 1) pulse(s == 0 ? 1 : 5);
        meas(n, !clr);
        drain();
    endtask : ev

    initial begin
        {hsel, hwrite, udp_we, udp_re, meas_valid, meas_last} = '0;
        {stall, mz_present, bpm, b_seen, hresetn, net_force_default} = '0;
        {haddr, hwdata, udp_addr, udp_wdata, meas_data, mz_spill} = '0;
        {htrans, tag, trg} = '0;
        hsize = 3'h2;
        void'($urandom(7));
        net_eeprom_ip = $urandom;
        net_eeprom_mac = 48'({$urandom, $urandom});
        do_reset(1'b0);
        chk("act ip", net_active_ip, net_eeprom_ip);
        chk("act mac", net_active_mac, net_eeprom_mac);
        chk("eeprom read", rd_seen, 1);
        chk("speed", {net_speed_1g, net_autofallback_en}, 2'b10);
        chk("tcp rx", {tcp_rx_ready, hresp}, 0);
        rchk("ctrl rst", 32'(REG_CTRL), 32'(CTRL_RST));
        nip = $urandom;
        wr(32'(REG_ACT_IP), ~nip);
        wr(32'(REG_NEW_IP), nip);
        repeat (2) @(posedge hclk);
        chk("eeprom wr", wr_cnt, 1);
        chk("eeprom ip", cap_ip, nip);
        chk("ip kept", net_active_ip, net_eeprom_ip);
        rchk("new ip", 32'(REG_NEW_IP), nip);
        rchk("act ip ro", 32'(REG_ACT_IP), net_eeprom_ip);
        wr(32'h100, 32'hFFFFFFFF);
        rchk("unmapped", 32'h100, 32'h0);
        rchk("ctrl kept", 32'(REG_CTRL), 32'(CTRL_RST));
        net_eeprom_ip = nip;
        do_reset(1'b0);
        chk("ip reload", net_active_ip, nip);
        do_reset(1'b1);
        chk("def ip", net_active_ip, DEF_IP);
        chk("def mac", net_active_mac, DEF_MAC);
        chk("no eeprom", rd_seen, 0);
        rchk("status", 32'(REG_STATUS), 32'h30);
        do_reset(1'b0);
        for (int i = 0; i < 6; i++) begin
            ua = $urandom;
            ud = 8'($urandom);
            udp(1'b1, ua, ud, 8'h00);
            udp(1'b0, ua, ~ud, ud);
        end
        @(posedge hclk);
        mz_present <= 1'b1;
        for (int s = 0; s < 3; s++) ev(2'(s), 3, 1'b0);
        bpm = 1'b1;
        b_seen = 1'b0;
        ev(2'h0, 4, 1'b1);
        chk("bp driven", {bp_oe, b_seen}, 2'b11);
        chk("bp tag", b_tag, tag);
        ev(2'h0, 2, 1'b0);
        bpm = 1'b0;
        wr(32'(REG_CTRL), 32'h0);
        repeat (3) @(posedge hclk);
        chk("bp released", bp_oe, 0);
        @(posedge hclk);
        stall <= 1'b1;
        refused = 0;
        fork
            begin
                repeat (80) @(posedge hclk);
                stall <= 1'b0;
            end
        join_none
        ev(2'h0, 12, 1'b0);
        chk("fifo refused", refused > 0, 1);
        rchk("evt cnt", 32'(REG_EVT_CNT), 32'h5);
        results();
    end
endmodule : tb_dntb_top
